// ===== hw/biu_map.svh
`ifndef BIU_MAP_SVH
`define BIU_MAP_SVH
// What this block does
// [RULE1] Four software request bits set their pending bits and interrupt the routed output.
// [RULE2] Software requests have no enable; a set request always reaches status and output.
// [RULE3] Software interrupt drives its line while pending; writing one clears pending.
// [RULE4] Power change and six list sources each own enable, route and pending bits.
// [RULE5] An interrupt in one channel never stalls or alters the other channel.
// [RULE6] Rising configuration error flags set the config-status pending bit and interrupt.
// [RULE7] Config-status interrupt goes to the output picked by its own route bit.
// [RULE8] Master parity detected flag never feeds the config-status pending bit.
// [RULE9] Writing one to config-status pending clears the bit and its interrupt.
// [RULE10] A bus read of the acknowledge register starts a PCI acknowledge cycle.
// [RULE11] Acknowledge byte enables come from transfer size and low two address bits.
// [RULE12] The triggering read address is forwarded unchanged to the acknowledge cycle.
// [RULE13] Acknowledge reads are retried until data is latched, then returned on repeat.
// [RULE14] Writes to the acknowledge register from either bus change nothing.
// [RULE15] PCI reads of the acknowledge register return zero and start no cycle.
// [RULE16] The interrupt pin field resets to one.
// [RULE17] Interrupt pin field loads from serial config memory or the local bus.
// [RULE18] The interrupt pin field does not affect driving the PCI interrupt.
// [RULE19] Interrupt line field is read/write, resets to zero; unused means 0xFF.
// [RULE20] A hardware source reaches an output only while enabled; route picks which.
// [RULE21] Software clears the source condition before clearing its pending bit.
// [RULE22] Each output is the OR of pending, enabled sources routed to it.
// [RULE23] The route bit encoding is one fixed parameter for every source.

// Register byte offsets
`define BIU_OFS_STAT 8'h00
`define BIU_OFS_ENABLE 8'h04
`define BIU_OFS_ROUTE 8'h08
`define BIU_OFS_SWREQ 8'h0C
`define BIU_OFS_IACK 8'h10
`define BIU_OFS_MISC 8'h14
`define BIU_OFS_CFGST 8'h18
// Status bit positions
`define BIU_BIT_PWR 0
`define BIU_BIT_LIST 1
`define BIU_BIT_CFG 7
`define BIU_BIT_SW 8
`define BIU_NUM_HW 8
`define BIU_NUM_SW 4
`define BIU_NUM_SRC 12
// Config flag vector: bit 5 is the master parity flag
`define BIU_CFG_FLAGS 6
`define BIU_CFG_MASK 6'h1F
// Misc register fields
`define BIU_LINE_LSB 0
`define BIU_PIN_LSB 8
`define BIU_PIN_RESET 8'h01
`define BIU_LINE_RESET 8'h00
`endif

// ===== hw/biu_pkg.sv
package biu_pkg;
   typedef enum logic [1:0] {
      BIU_IDLE = 2'b00,
      BIU_BUSY = 2'b01,
      BIU_READY = 2'b11
   } biu_state_type;
   typedef struct packed {
      logic [31:0] addr;
      logic [3:0] byte_en;
   } biu_iack_type;
endpackage : biu_pkg

// ===== hw/biu_bridge_interrupt_unit.sv
// Register access over Wishbone and the address map were left to the implementer.
`timescale 1ns/1ps
`include "biu_map.svh"
module biu_bridge_interrupt_unit
   import biu_pkg::*;
#(
   parameter int ADDR_W = 32,
   parameter bit ROUTE_PCI = 1'b1
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [ADDR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic wb_err_o,
   output logic wb_rty_o,
   input wire logic [1:0] qbus_xfer_size,
   input wire logic power_change_src,
   input wire logic [5:0] list_src,
   input wire logic [`BIU_CFG_FLAGS-1:0] cfg_flags,
   output logic qbus_irq_out_n,
   output logic pci_inta_n,
   output logic iack_req,
   output biu_iack_type iack_cmd,
   input wire logic iack_done,
   input wire logic [31:0] iack_data,
   input wire logic pci_reg_rd,
   input wire logic pci_reg_wr,
   input wire logic pci_reg_is_iack,
   input wire logic pci_reg_is_misc,
   input wire logic [31:0] pci_reg_wdata,
   output logic [31:0] pci_reg_rdata,
   input wire logic eeprom_load,
   input wire logic [7:0] eeprom_int_pin
);

   if (ADDR_W < 8 || ADDR_W > 32) begin : g_chk
      $error("ADDR_W must be 8 to 32");
   end

   // ****************************************
   // Bus decode
   // ****************************************
   logic req;
   logic resp_r;
   logic [7:0] ofs;
   logic hit;
   logic is_iack;
   logic [31:0] wmask;
   logic [31:0] wd;
   logic wr_stat;
   logic wr_en;
   logic wr_route;
   logic wr_swreq;
   logic wr_misc;
   logic rd_iack;

   assign req = wb_cyc_i && wb_stb_i && !resp_r;
   assign ofs = wb_adr_i[7:0];
   assign is_iack = (ofs[7:2] == `BIU_OFS_IACK >> 2);
   assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
   assign wd = wb_dat_i & wmask;

   always_comb begin
      hit = 1'b1;
      if (ofs[7:2] == `BIU_OFS_STAT >> 2) begin
      end else if (ofs[7:2] == `BIU_OFS_ENABLE >> 2) begin
      end else if (ofs[7:2] == `BIU_OFS_ROUTE >> 2) begin
      end else if (ofs[7:2] == `BIU_OFS_SWREQ >> 2) begin
      end else if (is_iack) begin
      end else if (ofs[7:2] == `BIU_OFS_MISC >> 2) begin
      end else if (ofs[7:2] == `BIU_OFS_CFGST >> 2) begin
      end else begin
         hit = 1'b0;
      end
   end

   assign wr_stat = req && wb_we_i && (ofs[7:2] == `BIU_OFS_STAT >> 2);
   assign wr_en = req && wb_we_i && (ofs[7:2] == `BIU_OFS_ENABLE >> 2);
   assign wr_route = req && wb_we_i && (ofs[7:2] == `BIU_OFS_ROUTE >> 2);
   assign wr_swreq = req && wb_we_i && (ofs[7:2] == `BIU_OFS_SWREQ >> 2);
   assign wr_misc = req && wb_we_i && (ofs[7:2] == `BIU_OFS_MISC >> 2);
   assign rd_iack = req && !wb_we_i && is_iack;

   // ****************************************
   // Interrupt sources
   // ****************************************
   logic [`BIU_NUM_HW-1:0] en_r;
   logic [`BIU_NUM_SRC-1:0] route_r;
   logic [`BIU_NUM_SW-1:0] sw_req_r;
   logic [`BIU_NUM_SRC-1:0] stat_r;
   logic [`BIU_NUM_SRC-1:0] stat_nxt;
   logic [`BIU_CFG_FLAGS-1:0] cfg_prev_r;
   logic cfg_rise;
   logic [`BIU_NUM_SRC-1:0] set_vec;
   logic [`BIU_NUM_SRC-1:0] en_full;
   logic [`BIU_NUM_SRC-1:0] to_pci;

   // Master parity flag masked out: it has its own source elsewhere
   assign cfg_rise = |(cfg_flags & ~cfg_prev_r & `BIU_CFG_MASK); // [RULE6] [RULE8]

   // Levels re-set pending every cycle, so a live source survives a clear
   assign set_vec = {sw_req_r, cfg_rise, list_src, power_change_src}; // [RULE1] [RULE4] [RULE21]
   assign stat_nxt = (stat_r & ~(wr_stat ? wd[`BIU_NUM_SRC-1:0] : '0)) | set_vec; // [RULE3] [RULE9]

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         stat_r <= '0;
         cfg_prev_r <= '0;
      end else begin
         stat_r <= stat_nxt;
         cfg_prev_r <= cfg_flags;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         en_r <= '0;
         route_r <= '0;
         sw_req_r <= '0;
      end else begin
         if (wr_en) begin
            en_r <= (en_r & ~wmask[`BIU_NUM_HW-1:0]) | wd[`BIU_NUM_HW-1:0];
         end
         if (wr_route) begin
            route_r <= (route_r & ~wmask[`BIU_NUM_SRC-1:0]) | wd[`BIU_NUM_SRC-1:0];
         end
         if (wr_swreq) begin
            sw_req_r <= (sw_req_r & ~wmask[`BIU_NUM_SW-1:0]) | wd[`BIU_NUM_SW-1:0];
         end
      end
   end

   // ****************************************
   // Output routing
   // ****************************************
   // Software sources carry no enable
   assign en_full = {{`BIU_NUM_SW{1'b1}}, en_r}; // [RULE2] [RULE20]
   assign to_pci = ROUTE_PCI ? route_r : ~route_r; // [RULE7] [RULE23]

   // Pin field is deliberately absent here
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         pci_inta_n <= 1'b1;
         qbus_irq_out_n <= 1'b1;
      end else begin
         pci_inta_n <= !(|(stat_nxt & en_full & to_pci)); // [RULE22] [RULE18]
         qbus_irq_out_n <= !(|(stat_nxt & en_full & ~to_pci)); // [RULE22]
      end
   end

   // ****************************************
   // Acknowledge cycle
   // ****************************************
   biu_state_type state_r;
   logic [31:0] iack_data_r;
   logic [3:0] be_calc;

   always_comb begin
      logic [2:0] nbytes;
      nbytes = (qbus_xfer_size == 2'b00) ? 3'd4 : {1'b0, qbus_xfer_size};
      be_calc = 4'h0;
      for (int i = 0; i < 4; i++) begin
         if (i >= int'(wb_adr_i[1:0]) && i < int'(wb_adr_i[1:0]) + int'(nbytes)) begin
            be_calc[i] = 1'b1; // [RULE11]
         end
      end
   end

   // Own master port: local bus traffic elsewhere never waits on it
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         state_r <= BIU_IDLE;
         iack_cmd <= '0;
         iack_data_r <= '0;
      end else begin
         case (state_r)
            BIU_IDLE: begin
               if (rd_iack) begin
                  state_r <= BIU_BUSY; // [RULE10] [RULE5]
                  iack_cmd.addr <= 32'(wb_adr_i); // [RULE12]
                  iack_cmd.byte_en <= be_calc; // [RULE11]
               end
            end
            BIU_BUSY: begin
               if (iack_done) begin
                  iack_data_r <= iack_data; // [RULE13]
                  state_r <= BIU_READY;
               end
            end
            BIU_READY: begin
               if (rd_iack) begin
                  state_r <= BIU_IDLE; // [RULE13]
               end
            end
            default: begin
               state_r <= BIU_IDLE;
            end
         endcase
      end
   end

   assign iack_req = (state_r == BIU_BUSY);

   // ****************************************
   // Bus response
   // ****************************************
   logic [7:0] line_r;
   logic [7:0] pin_r;

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         wb_ack_o <= 1'b0;
         wb_err_o <= 1'b0;
         wb_rty_o <= 1'b0;
         wb_dat_o <= '0;
      end else begin
         wb_ack_o <= 1'b0;
         wb_err_o <= 1'b0;
         wb_rty_o <= 1'b0;
         if (req) begin
            wb_dat_o <= '0;
            if (!hit) begin
               wb_err_o <= 1'b1;
            end else if (rd_iack && state_r != BIU_READY) begin
               wb_rty_o <= 1'b1; // [RULE13]
            end else begin
               wb_ack_o <= 1'b1; // [RULE14]
               if (!wb_we_i) begin
                  if (ofs[7:2] == `BIU_OFS_STAT >> 2) begin
                     wb_dat_o <= 32'(stat_r);
                  end else if (ofs[7:2] == `BIU_OFS_ENABLE >> 2) begin
                     wb_dat_o <= 32'(en_r);
                  end else if (ofs[7:2] == `BIU_OFS_ROUTE >> 2) begin
                     wb_dat_o <= 32'(route_r);
                  end else if (ofs[7:2] == `BIU_OFS_SWREQ >> 2) begin
                     wb_dat_o <= 32'(sw_req_r);
                  end else if (is_iack) begin
                     wb_dat_o <= iack_data_r; // [RULE13]
                  end else if (ofs[7:2] == `BIU_OFS_MISC >> 2) begin
                     wb_dat_o <= {16'h0000, pin_r, line_r};
                  end else begin
                     wb_dat_o <= 32'(cfg_flags);
                  end
               end
            end
         end
      end
   end

   assign resp_r = wb_ack_o || wb_err_o || wb_rty_o;

   // ****************************************
   // Config fields and PCI target reads
   // ****************************************
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         pin_r <= `BIU_PIN_RESET; // [RULE16]
         line_r <= `BIU_LINE_RESET; // [RULE19]
      end else begin
         if (eeprom_load) begin
            pin_r <= eeprom_int_pin; // [RULE17]
         end else if (wr_misc && wb_sel_i[1]) begin
            pin_r <= wb_dat_i[`BIU_PIN_LSB+:8]; // [RULE17]
         end
         if (pci_reg_wr && pci_reg_is_misc) begin
            line_r <= pci_reg_wdata[`BIU_LINE_LSB+:8]; // [RULE19]
         end else if (wr_misc && wb_sel_i[0]) begin
            line_r <= wb_dat_i[`BIU_LINE_LSB+:8]; // [RULE19]
         end
      end
   end

   // PCI side sees zero for the acknowledge register and never triggers it
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         pci_reg_rdata <= '0;
      end else if (pci_reg_rd) begin
         pci_reg_rdata <= pci_reg_is_misc ? {16'h0000, pin_r, line_r} : 32'h00000000; // [RULE15]
      end
   end

   // ****************************************
   // Assertions
   // ****************************************
   sw_set_a: assert property (@(posedge clock) disable iff (!rst_n) // [RULE1]
      (sw_req_r[0] ##1 sw_req_r[0]) |-> stat_r[`BIU_BIT_SW])
      else $error("software request did not set pending");
   sw_drive_a: assert property (@(posedge clock) disable iff (!rst_n) // [RULE2]
      (stat_r[`BIU_BIT_SW] && to_pci[`BIU_BIT_SW] && !(wr_stat && wd[`BIU_BIT_SW])) |=> !pci_inta_n)
      else $error("software pending not driving pci");
   sw_clear_a: assert property (@(posedge clock) disable iff (!rst_n) // [RULE3]
      (wr_stat && wd[`BIU_BIT_SW] && !sw_req_r[0]) |=> !stat_r[`BIU_BIT_SW])
      else $error("software pending not cleared");
   cfg_set_a: assert property (@(posedge clock) disable iff (!rst_n) // [RULE6]
      cfg_rise |=> stat_r[`BIU_BIT_CFG])
      else $error("config flag rise lost");
   md_excl_a: assert property (@(posedge clock) disable iff (!rst_n) // [RULE8]
      (!stat_r[`BIU_BIT_CFG] && cfg_flags[5] && !cfg_prev_r[5] && (cfg_flags[4:0] & ~cfg_prev_r[4:0]) == 5'h00)
      |=> !stat_r[`BIU_BIT_CFG])
      else $error("master parity fed config status");
   cfg_clr_a: assert property (@(posedge clock) disable iff (!rst_n) // [RULE9]
      (wr_stat && wd[`BIU_BIT_CFG] && !cfg_rise) |=> !stat_r[`BIU_BIT_CFG])
      else $error("config status not cleared");
   hw_gate_a: assert property (@(posedge clock) disable iff (!rst_n) // [RULE20]
      ((stat_nxt[`BIU_NUM_HW-1:0] & en_r) == 8'h00 && stat_nxt[`BIU_NUM_SRC-1:`BIU_BIT_SW] == 4'h0)
      |=> pci_inta_n && qbus_irq_out_n)
      else $error("output without pending source");
   iack_go_a: assert property (@(posedge clock) disable iff (!rst_n) // [RULE10]
      (rd_iack && state_r == BIU_IDLE) |=> iack_req && wb_rty_o && iack_cmd.addr == 32'($past(wb_adr_i)))
      else $error("acknowledge cycle not started");
   iack_ret_a: assert property (@(posedge clock) disable iff (!rst_n) // [RULE13]
      (rd_iack && state_r == BIU_READY) |=> wb_ack_o && wb_dat_o == $past(iack_data_r) && state_r == BIU_IDLE)
      else $error("latched acknowledge data not returned");
   iack_wr_a: assert property (@(posedge clock) disable iff (!rst_n) // [RULE14]
      (req && wb_we_i && is_iack && !iack_done) |=> $stable(state_r) && $stable(iack_data_r))
      else $error("write changed acknowledge state");
   pci_zero_a: assert property (@(posedge clock) disable iff (!rst_n) // [RULE15]
      (pci_reg_rd && pci_reg_is_iack && !pci_reg_is_misc) |=> pci_reg_rdata == 32'h00000000)
      else $error("pci acknowledge read not zero");
   pin_rst_a: assert property (@(posedge clock) // [RULE16]
      $past(!rst_n) |-> pin_r == `BIU_PIN_RESET && line_r == `BIU_LINE_RESET)
      else $error("config fields wrong after reset");

endmodule : biu_bridge_interrupt_unit

// ===== testbench/biu_pci_master_model.sv
`timescale 1ns/1ps
// ****************
// PCI master answering acknowledge cycles
// ****************
module biu_pci_master_model (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic iack_req,
   input wire logic [7:0] wait_cycles,
   input wire logic [31:0] answer,
   output logic iack_done,
   output logic [31:0] iack_data
);
   logic [7:0] count_r;
   logic busy_r;
   // Data toggles outside the done pulse so stale data never passes
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         busy_r <= 1'b0;
         count_r <= 8'h00;
         iack_done <= 1'b0;
         iack_data <= 32'h5A5A5A5A;
      end else begin
         iack_done <= 1'b0;
         iack_data <= ~iack_data;
         if (!busy_r && !iack_done && iack_req) begin
            busy_r <= 1'b1;
            count_r <= wait_cycles;
         end else if (busy_r && count_r != 8'h00) begin
            count_r <= count_r - 8'h01;
         end else if (busy_r) begin
            busy_r <= 1'b0;
            iack_done <= 1'b1;
            iack_data <= answer;
         end
      end
   end
endmodule : biu_pci_master_model

// ===== testbench/testbench.sv
`timescale 1ns/1ps
`include "biu_map.svh"
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin failures++; \
   $display("wrong value at %0t: got %h expected %h", $time, got, exp); end end
module testbench;
   import biu_pkg::*;
   localparam bit ROUTE_PCI_TB = 1'b1;
   logic clock = 1'b0;
   logic rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, wb_err_o, wb_rty_o, power_change_src;
   logic qbus_irq_out_n, pci_inta_n, iack_req, iack_done, pci_reg_rd, pci_reg_wr, pci_reg_is_iack;
   logic pci_reg_is_misc, eeprom_load, seen_req, rb;
   logic [31:0] wb_adr_i, wb_dat_i, wb_dat_o, iack_data, pci_reg_wdata, pci_reg_rdata, rq, answer;
   logic [3:0] wb_sel_i;
   logic [1:0] qbus_xfer_size, rr, a;
   logic [5:0] list_src, cfg_flags;
   logic [7:0] eeprom_int_pin, wait_cycles;
   biu_iack_type iack_cmd;
   int seed, failures, checks_done, n, cnt;
   always #10 clock = ~clock;
   biu_bridge_interrupt_unit #(.ROUTE_PCI(ROUTE_PCI_TB)) dut (.clock(clock), .rst_n(rst_n),
      .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
      .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .wb_rty_o(wb_rty_o),
      .qbus_xfer_size(qbus_xfer_size), .power_change_src(power_change_src), .list_src(list_src),
      .cfg_flags(cfg_flags), .qbus_irq_out_n(qbus_irq_out_n), .pci_inta_n(pci_inta_n), .iack_req(iack_req),
      .iack_cmd(iack_cmd), .iack_done(iack_done), .iack_data(iack_data), .pci_reg_rd(pci_reg_rd),
      .pci_reg_wr(pci_reg_wr), .pci_reg_is_iack(pci_reg_is_iack), .pci_reg_is_misc(pci_reg_is_misc),
      .pci_reg_wdata(pci_reg_wdata), .pci_reg_rdata(pci_reg_rdata), .eeprom_load(eeprom_load),
      .eeprom_int_pin(eeprom_int_pin));
   biu_pci_master_model far_end (.clock(clock), .rst_n(rst_n), .iack_req(iack_req), .wait_cycles(wait_cycles),
      .answer(answer), .iack_done(iack_done), .iack_data(iack_data));
   always @(posedge clock) begin
      if (iack_req === 1'b1) begin
         seen_req = 1'b1;
      end
   end
   // ****************
   // Expectations and bus tasks
   // ****************
   function automatic logic [1:0] pins(input logic on, input logic r);
      if (!on) return 2'b11;
      return (r == ROUTE_PCI_TB) ? 2'b10 : 2'b01;
   endfunction : pins
   function automatic logic [3:0] be_exp(input logic [1:0] size, input logic [1:0] lo);
      logic [2:0] bytes;
      bytes = (size == 2'b00) ? 3'd4 : {1'b0, size};
      return 4'(((5'h01 << bytes) - 5'h01) << lo);
   endfunction : be_exp
   task automatic give_verdict;
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : give_verdict
   task automatic time_out;
      failures++;
      give_verdict();
   endtask : time_out
   task automatic tick(input int c);
      repeat (c) @(posedge clock);
   endtask : tick
   task automatic wb(input logic we, input logic [31:0] adr, input logic [31:0] d, input logic [3:0] sel);
      int w;
      @(posedge clock);
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} <= {2'b11, we, adr, sel, d};
      w = 0;
      do begin
         @(posedge clock);
         w++;
      end while (!(wb_ack_o || wb_err_o || wb_rty_o) && w < 50);
      if (!(wb_ack_o || wb_err_o || wb_rty_o)) time_out();
      rq = wb_dat_o;
      rr = wb_rty_o ? 2'd2 : (wb_err_o ? 2'd1 : 2'd0);
      {wb_cyc_i, wb_stb_i} <= 2'b00;
   endtask : wb
   task automatic pci(input logic wr, input logic iack, input logic [31:0] d);
      @(posedge clock);
      {pci_reg_rd, pci_reg_wr, pci_reg_is_iack, pci_reg_is_misc, pci_reg_wdata} <= {!wr, wr, iack, !iack, d};
      @(posedge clock);
      {pci_reg_rd, pci_reg_wr} <= 2'b00;
      @(negedge clock);
   endtask : pci
   // ****************
   // Main sequence
   // ****************
   initial begin
      seed = 48225;
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i, qbus_xfer_size, power_change_src} = '0;
      {list_src, cfg_flags, pci_reg_rd, pci_reg_wr, pci_reg_is_iack, pci_reg_is_misc, pci_reg_wdata} = '0;
      {eeprom_load, eeprom_int_pin, wait_cycles, answer, seen_req} = '0;
      rst_n = 1'b0;
      repeat (6) @(posedge clock);
      rst_n <= 1'b1;
      wb(1'b0, `BIU_OFS_MISC, 32'h0, 4'hF);
      `CHK(rq, 32'h00000100)
      wb(1'b1, `BIU_OFS_MISC, 32'h000077AA, 4'h1);
      wb(1'b0, `BIU_OFS_MISC, 32'h0, 4'hF);
      `CHK(rq, 32'h000001AA)
      @(posedge clock);
      {eeprom_load, eeprom_int_pin} <= 9'h100;
      @(posedge clock);
      eeprom_load <= 1'b0;
      pci(1'b1, 1'b0, 32'h000000FF);
      pci(1'b0, 1'b0, 32'h0);
      `CHK(pci_reg_rdata, 32'h000000FF)
      pci(1'b1, 1'b1, 32'hFFFFFFFF);
      pci(1'b0, 1'b1, 32'h0);
      `CHK(pci_reg_rdata, 32'h0)
      wb(1'b1, `BIU_OFS_IACK, 32'hFFFFFFFF, 4'hF);
      `CHK({rr, seen_req}, 3'b000)
      for (int i = 0; i < 4; i++) begin
         rb = 1'($random(seed));
         wb(1'b1, `BIU_OFS_ROUTE, 32'(rb) << (8 + i), 4'hF);
         wb(1'b1, `BIU_OFS_SWREQ, 32'h1 << i, 4'hF);
         tick(3);
         `CHK({qbus_irq_out_n, pci_inta_n}, pins(1'b1, rb))
         wb(1'b0, `BIU_OFS_STAT, 32'h0, 4'hF);
         `CHK(rq[8 + i], 1'b1)
         wb(1'b1, `BIU_OFS_SWREQ, 32'h0, 4'hF);
         tick(2);
         `CHK({qbus_irq_out_n, pci_inta_n}, pins(1'b1, rb))
         wb(1'b1, `BIU_OFS_STAT, 32'h1 << (8 + i), 4'hF);
         tick(3);
         `CHK({qbus_irq_out_n, pci_inta_n}, 2'b11)
      end
      for (int j = 0; j < 7; j++) begin
         rb = 1'($random(seed));
         @(posedge clock);
         {list_src, power_change_src} <= 7'(7'h01 << j);
         wb(1'b1, `BIU_OFS_ROUTE, 32'(rb) << j, 4'hF);
         tick(3);
         `CHK({qbus_irq_out_n, pci_inta_n}, 2'b11)
         wb(1'b1, `BIU_OFS_ENABLE, 32'h1 << j, 4'hF);
         tick(2);
         `CHK({qbus_irq_out_n, pci_inta_n}, pins(1'b1, rb))
         @(posedge clock);
         {list_src, power_change_src} <= 7'h00;
         wb(1'b1, `BIU_OFS_STAT, 32'h1 << j, 4'hF);
         wb(1'b1, `BIU_OFS_ENABLE, 32'h0, 4'hF);
         tick(2);
         `CHK({qbus_irq_out_n, pci_inta_n}, 2'b11)
      end
      wb(1'b1, `BIU_OFS_ENABLE, 32'h80, 4'hF);
      @(posedge clock);
      cfg_flags <= 6'h20;
      tick(3);
      wb(1'b0, `BIU_OFS_STAT, 32'h0, 4'hF);
      `CHK(rq[7], 1'b0)
      for (int k = 0; k < 5; k++) begin
         rb = 1'($random(seed));
         wb(1'b1, `BIU_OFS_ROUTE, 32'(rb) << 7, 4'hF);
         @(posedge clock);
         cfg_flags <= 6'(6'h01 << k);
         tick(3);
         `CHK({qbus_irq_out_n, pci_inta_n}, pins(1'b1, rb))
         @(posedge clock);
         cfg_flags <= 6'h00;
         wb(1'b1, `BIU_OFS_STAT, 32'h80, 4'hF);
         wb(1'b0, `BIU_OFS_STAT, 32'h0, 4'hF);
         `CHK({rq[7], qbus_irq_out_n, pci_inta_n}, 3'b011)
      end
      for (int t = 0; t < 3; t++) begin
         a = 2'($random(seed));
         n = 1 + {$random(seed)} % (4 - a);
         @(posedge clock);
         {qbus_xfer_size, wait_cycles, answer} <= {2'(n), 8'(t * 9), 32'($random(seed))};
         wb(1'b0, {24'h0, 6'h04, a}, 32'h0, 4'hF);
         `CHK(rr, 2'd2)
         `CHK({iack_req, iack_cmd}, {1'b1, 24'h0, 6'h04, a, be_exp(2'(n), a)})
         wb(1'b0, `BIU_OFS_STAT, 32'h0, 4'hF);
         `CHK(rr, 2'd0)
         cnt = 0;
         do begin
            wb(1'b0, {24'h0, 6'h04, a}, 32'h0, 4'hF);
            cnt++;
         end while (rr == 2'd2 && cnt < 40);
         `CHK({rr, rq}, {2'd0, answer})
      end
      // Mid-run reset must bring config fields and outputs back
      @(posedge clock);
      rst_n <= 1'b0;
      tick(2);
      `CHK({wb_ack_o, iack_req, qbus_irq_out_n, pci_inta_n}, 4'b0011)
      rst_n <= 1'b1;
      wb(1'b0, `BIU_OFS_MISC, 32'h0, 4'hF);
      `CHK(rq, 32'h00000100)
      wb(1'b0, 32'h0000001C, 32'h0, 4'hF);
      `CHK(rr, 2'd1)
      give_verdict();
   end
endmodule : testbench
